// ### hdl/bmrs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "bmrs_cfg.svh"
// Notes on behaviour
// - master samples four strap pins once after internal reset releases.
// - unassigned strap values fall back to running master flash.
// - strap 0000b loads master image over parallel pins, then branches.
// - strap 0010b loads via uart, sync serial or i2c, slaves.
// - strap 0011b loads master image through can interface.
// - strap 0100b loads master image through ethernet interface.
// - 1001b sync serial, 1010b i2c, device as bus master.
// - modes 1, 7, 15 perform no load; run flash or ram.
// - once image resides, branch and hand control to application.
// - command 1 branches control to ram entry point.
// - command 2 branches control to flash entry point.
// - commands 3, 4, 5 load from serial comms, spi, i2c.
// - command 6 loads control image over parallel pins.
// - after boot, control still decodes further mailbox commands.
// - power-on reset holds both reset pins low.
// - reset pins open-drain; external low keeps device in reset.
// - during power-on reset, subsystems reset and gpio high impedance.
// - merge controller, watchdog and nmi requests, and with por.
// - only master leaves reset; others await release bits set to 1.
module bmrs_sequencer
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        por_n_in,
  input  wire logic        analog_reset_pin_in,
  output logic             analog_reset_pin_out,
  output logic             analog_reset_pin_oe_out,
  input  wire logic        digital_reset_pin_in,
  output logic             digital_reset_pin_out,
  output logic             digital_reset_pin_oe_out,
  input  wire logic        irq_ctrl_rst_req_in,
  input  wire logic        wdog0_rst_req_in,
  input  wire logic        wdog1_rst_req_in,
  input  wire logic        nmi_wdog_rst_req_in,
  input  wire logic [3:0]  strap_in,
  input  wire logic        master_load_done_in,
  input  wire logic        control_reset_release_in,
  input  wire logic        analog_reset_release_in,
  input  wire logic        master_to_control_wake_irq_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [31:0] control_boot_command_mailbox_in,
  input  wire logic        control_load_done_in,
  output logic             master_reset_out,
  output logic             control_reset_out,
  output logic             analog_reset_out,
  output logic             gpio_hiz_out,
  output logic [3:0]       strap_latched_out,
  output logic [3:0]       master_src_out,
  output logic             master_load_out,
  output logic             master_run_out,
  output logic             control_idle_out,
  output logic [2:0]       control_src_out,
  output logic             control_load_out,
  output logic             control_run_out,
  output logic             cmd_taken_out,
  output logic             cmd_ignored_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    bmrs_pkg::bmrs_mst_e  mst;
    bmrs_pkg::bmrs_cst_e  cst;
    logic [3:0]           strap;
    bmrs_pkg::bmrs_msrc_e msrc;
    bmrs_pkg::bmrs_csrc_e csrc;
    logic                 crun;
    logic                 ctl_rel;
    logic                 ana_rel;
    logic                 taken;
    logic                 ignored;
  } bmrs_state_s;

  bmrs_state_s          st_r;
  bmrs_state_s          st_nxt;
  logic                 int_reset;
  logic                 sys_req_n;
  logic [3:0]           req_vec;
  logic [3:0]           req_acc;
  logic                 dec_valid;
  logic                 dec_load;
  bmrs_pkg::bmrs_csrc_e dec_src;

  // ----------------------------------------
  // reset merge and pins
  // ----------------------------------------
  // low-active: por and internal requests combined
  assign req_vec = {nmi_wdog_rst_req_in, wdog1_rst_req_in,
                    wdog0_rst_req_in, irq_ctrl_rst_req_in};
  generate
    for (genvar gi = 0; gi < 4; gi++)
    begin : g_req
      if (gi == 0)
      begin : g_first
        assign req_acc[gi] = req_vec[gi];
      end
      else
      begin : g_rest
        assign req_acc[gi] = req_acc[gi - 1] | req_vec[gi];
      end
    end
  endgenerate
  assign sys_req_n = ~req_acc[3];
  // drive low: oe low means driving, open-drain ties out to 0
  assign digital_reset_pin_out    = 1'b0;
  assign digital_reset_pin_oe_out = por_n_in & sys_req_n;
  assign analog_reset_pin_out     = 1'b0;
  assign analog_reset_pin_oe_out  = por_n_in;
  // external low on either pin keeps device in reset
  assign int_reset = rst_in | ~por_n_in | ~digital_reset_pin_in
                     | ~analog_reset_pin_in;
  assign gpio_hiz_out = int_reset;

  bmrs_cmd_decode u_dec
  (
    .cmd_in    (control_boot_command_mailbox_in),
    .valid_out (dec_valid),
    .load_out  (dec_load),
    .src_out   (dec_src)
  );

  // ----------------------------------------
  // master strap decode
  // ----------------------------------------
  function automatic bmrs_pkg::bmrs_msrc_e strap_src(input logic [3:0] s);
    unique case (s)
      `BMRS_STRAP_PARALLEL:   strap_src = bmrs_pkg::BMRS_SRC_PARALLEL;
      `BMRS_STRAP_RAM:        strap_src = bmrs_pkg::BMRS_SRC_RAM;
      `BMRS_STRAP_SERIAL_SLV: strap_src = bmrs_pkg::BMRS_SRC_SERIAL_SLV;
      `BMRS_STRAP_CAN:        strap_src = bmrs_pkg::BMRS_SRC_CAN;
      `BMRS_STRAP_ETH:        strap_src = bmrs_pkg::BMRS_SRC_ETH;
      `BMRS_STRAP_SSI_MST:    strap_src = bmrs_pkg::BMRS_SRC_SSI_MST;
      `BMRS_STRAP_I2C_MST:    strap_src = bmrs_pkg::BMRS_SRC_I2C_MST;
      default:                strap_src = bmrs_pkg::BMRS_SRC_FLASH;
    endcase
  endfunction : strap_src

  function automatic logic needs_load(input bmrs_pkg::bmrs_msrc_e m);
    needs_load = (m != bmrs_pkg::BMRS_SRC_RAM)
                 && (m != bmrs_pkg::BMRS_SRC_FLASH);
  endfunction : needs_load

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.taken   = 1'b0;
    st_nxt.ignored = 1'b0;
    unique case (st_r.mst)
      bmrs_pkg::BMRS_M_RESET:
        st_nxt.mst = bmrs_pkg::BMRS_M_SAMPLE;
      bmrs_pkg::BMRS_M_SAMPLE:
      begin
        st_nxt.strap = strap_in;
        st_nxt.msrc  = strap_src(strap_in);
        st_nxt.mst   = needs_load(strap_src(strap_in))
                       ? bmrs_pkg::BMRS_M_LOAD : bmrs_pkg::BMRS_M_RUN;
      end
      bmrs_pkg::BMRS_M_LOAD:
        if (master_load_done_in)
        begin
          st_nxt.mst = bmrs_pkg::BMRS_M_RUN;
        end
      bmrs_pkg::BMRS_M_RUN:
      begin
        // release bits only take effect while master runs
        if (control_reset_release_in)
        begin
          st_nxt.ctl_rel = 1'b1;
        end
        if (analog_reset_release_in)
        begin
          st_nxt.ana_rel = 1'b1;
        end
      end
    endcase
    unique case (st_r.cst)
      bmrs_pkg::BMRS_C_RESET:
        if (st_r.ctl_rel)
        begin
          st_nxt.cst = bmrs_pkg::BMRS_C_IDLE;
        end
      bmrs_pkg::BMRS_C_IDLE:
        if (master_to_control_wake_irq_in)
        begin
          st_nxt.cst = bmrs_pkg::BMRS_C_WAIT;
        end
      bmrs_pkg::BMRS_C_WAIT, bmrs_pkg::BMRS_C_LOAD:
      begin
        if (st_r.cst == bmrs_pkg::BMRS_C_LOAD && control_load_done_in)
        begin
          st_nxt.cst  = bmrs_pkg::BMRS_C_WAIT;
          st_nxt.crun = 1'b1;
        end
        if (cmd_valid_in)
        begin
          if (dec_valid)
          begin
            st_nxt.taken = 1'b1;
            st_nxt.csrc  = dec_src;
            st_nxt.crun  = ~dec_load;
            st_nxt.cst   = dec_load ? bmrs_pkg::BMRS_C_LOAD
                                    : bmrs_pkg::BMRS_C_WAIT;
          end
          else
          begin
            st_nxt.ignored = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (int_reset)
    begin
      st_r.mst     <= bmrs_pkg::BMRS_M_RESET;
      st_r.cst     <= bmrs_pkg::BMRS_C_RESET;
      st_r.strap   <= 4'h0;
      st_r.msrc    <= bmrs_pkg::BMRS_SRC_FLASH;
      st_r.csrc    <= bmrs_pkg::BMRS_CSRC_NONE;
      st_r.crun    <= 1'b0;
      st_r.ctl_rel <= `BMRS_RST_RELEASE;
      st_r.ana_rel <= `BMRS_RST_RELEASE;
      st_r.taken   <= 1'b0;
      st_r.ignored <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign master_reset_out  = st_r.mst == bmrs_pkg::BMRS_M_RESET;
  assign control_reset_out = ~st_r.ctl_rel;
  assign analog_reset_out  = ~st_r.ana_rel;
  assign strap_latched_out = st_r.strap;
  assign master_src_out    = st_r.msrc;
  assign master_load_out   = st_r.mst == bmrs_pkg::BMRS_M_LOAD;
  assign master_run_out    = st_r.mst == bmrs_pkg::BMRS_M_RUN;
  assign control_idle_out  = st_r.cst == bmrs_pkg::BMRS_C_IDLE;
  assign control_src_out   = st_r.csrc;
  assign control_load_out  = st_r.cst == bmrs_pkg::BMRS_C_LOAD;
  assign control_run_out   = st_r.crun;
  assign cmd_taken_out     = st_r.taken;
  assign cmd_ignored_out   = st_r.ignored;
endmodule : bmrs_sequencer
`default_nettype wire

// ### hdl/bmrs_cfg.svh
`ifndef BMRS_CFG_SVH
`define BMRS_CFG_SVH
// strap codes
`define BMRS_STRAP_PARALLEL   4'h0
`define BMRS_STRAP_RAM        4'h1
`define BMRS_STRAP_SERIAL_SLV 4'h2
`define BMRS_STRAP_CAN        4'h3
`define BMRS_STRAP_ETH        4'h4
`define BMRS_STRAP_FLASH      4'h7
`define BMRS_STRAP_SSI_MST    4'h9
`define BMRS_STRAP_I2C_MST    4'hA
`define BMRS_STRAP_FLASH_ALT  4'hF
// control boot commands
`define BMRS_CMD_RAM          32'h0000_0001
`define BMRS_CMD_FLASH        32'h0000_0002
`define BMRS_CMD_SERIAL       32'h0000_0003
`define BMRS_CMD_SPI          32'h0000_0004
`define BMRS_CMD_I2C          32'h0000_0005
`define BMRS_CMD_PARALLEL     32'h0000_0006
// reset values
`define BMRS_RST_RELEASE      1'b0
`endif

// ### hdl/bmrs_pkg.sv
package bmrs_pkg;
  typedef enum logic [3:0] {
    BMRS_SRC_PARALLEL   = 4'h0,
    BMRS_SRC_RAM        = 4'h1,
    BMRS_SRC_SERIAL_SLV = 4'h2,
    BMRS_SRC_CAN        = 4'h3,
    BMRS_SRC_ETH        = 4'h4,
    BMRS_SRC_FLASH      = 4'h7,
    BMRS_SRC_SSI_MST    = 4'h9,
    BMRS_SRC_I2C_MST    = 4'hA
  } bmrs_msrc_e;

  typedef enum logic [2:0] {
    BMRS_CSRC_NONE     = 3'h0,
    BMRS_CSRC_RAM      = 3'h1,
    BMRS_CSRC_FLASH    = 3'h2,
    BMRS_CSRC_SERIAL   = 3'h3,
    BMRS_CSRC_SPI      = 3'h4,
    BMRS_CSRC_I2C      = 3'h5,
    BMRS_CSRC_PARALLEL = 3'h6
  } bmrs_csrc_e;

  typedef enum logic [1:0] {
    BMRS_M_RESET  = 2'b00,
    BMRS_M_SAMPLE = 2'b01,
    BMRS_M_LOAD   = 2'b11,
    BMRS_M_RUN    = 2'b10
  } bmrs_mst_e;

  typedef enum logic [1:0] {
    BMRS_C_RESET = 2'b00,
    BMRS_C_IDLE  = 2'b01,
    BMRS_C_WAIT  = 2'b11,
    BMRS_C_LOAD  = 2'b10
  } bmrs_cst_e;
endpackage : bmrs_pkg

// ### hdl/bmrs_cmd_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "bmrs_cfg.svh"
module bmrs_cmd_decode
(
  input  wire logic [31:0]        cmd_in,
  output logic                    valid_out,
  output logic                    load_out,
  output bmrs_pkg::bmrs_csrc_e    src_out
);
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb
  begin
    valid_out = 1'b1;
    load_out  = 1'b1;
    src_out   = bmrs_pkg::BMRS_CSRC_NONE;
    unique case (cmd_in)
      `BMRS_CMD_RAM:
      begin
        src_out  = bmrs_pkg::BMRS_CSRC_RAM;
        load_out = 1'b0;
      end
      `BMRS_CMD_FLASH:
      begin
        src_out  = bmrs_pkg::BMRS_CSRC_FLASH;
        load_out = 1'b0;
      end
      `BMRS_CMD_SERIAL:   src_out = bmrs_pkg::BMRS_CSRC_SERIAL;
      `BMRS_CMD_SPI:      src_out = bmrs_pkg::BMRS_CSRC_SPI;
      `BMRS_CMD_I2C:      src_out = bmrs_pkg::BMRS_CSRC_I2C;
      `BMRS_CMD_PARALLEL: src_out = bmrs_pkg::BMRS_CSRC_PARALLEL;
      default:
      begin
        valid_out = 1'b0;
        load_out  = 1'b0;
      end
    endcase
  end
endmodule : bmrs_cmd_decode
`default_nettype wire

// ### test/bmrs_board.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// board pull-ups and boot host
// --------------------------------
module bmrs_board
(
  input  wire logic clk_in, a_oe_n_in, d_oe_n_in, hold_in,
  input  wire logic m_load_in, c_load_in,
  output logic      a_pin_n_out, d_pin_n_out, m_done_out, c_done_out
);
  logic [1:0] m_cnt_r = 2'h0;
  logic [1:0] c_cnt_r = 2'h0;
  // open drain with pull-up, board may stretch reset
  assign a_pin_n_out = a_oe_n_in & ~hold_in;
  assign d_pin_n_out = d_oe_n_in & ~hold_in;
  // host ends each load three cycles in
  assign m_done_out = &m_cnt_r;
  assign c_done_out = &c_cnt_r;
  always @(posedge clk_in)
  begin
    m_cnt_r <= (m_load_in === 1'b1) ? m_cnt_r + 2'h1 : 2'h0;
    c_cnt_r <= (c_load_in === 1'b1) ? c_cnt_r + 2'h1 : 2'h0;
  end
endmodule : bmrs_board
`default_nettype wire

// ### test/bmrs_checker.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// port checks on the sequencer
// --------------------------------
module bmrs_checker
(
  input wire logic mclk_in, rst_in, por_n_in, digital_reset_pin_in,
  input wire logic analog_reset_pin_oe_out, digital_reset_pin_oe_out,
  input wire logic irq_ctrl_rst_req_in, wdog0_rst_req_in,
  input wire logic wdog1_rst_req_in, nmi_wdog_rst_req_in,
  input wire logic control_reset_release_in, cmd_valid_in,
  input wire logic master_reset_out, control_reset_out, analog_reset_out,
  input wire logic gpio_hiz_out, master_load_out, master_run_out,
  input wire logic control_load_out, control_run_out,
  input wire logic cmd_taken_out, cmd_ignored_out,
  input wire logic [31:0] control_boot_command_mailbox_in,
  input wire logic [3:0]  strap_latched_out, master_src_out,
  input wire logic [2:0]  control_src_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic       any_req;
  logic [3:0] want_src;
  assign any_req = irq_ctrl_rst_req_in | wdog0_rst_req_in
                 | wdog1_rst_req_in | nmi_wdog_rst_req_in;
  assign want_src = (strap_latched_out inside {4'h0, 4'h1, 4'h2, 4'h3,
                    4'h4, 4'h7, 4'h9, 4'hA}) ? strap_latched_out : 4'h7;
  chk_por_pins_low:
    assert property (!por_n_in |-> !analog_reset_pin_oe_out
      && !digital_reset_pin_oe_out) else $error("pins free in por");
  chk_req_merge:
    assert property (digital_reset_pin_oe_out == (por_n_in & ~any_req))
      else $error("reset merge wrong");
  chk_pin_hold_hiz:
    assert property (!digital_reset_pin_in |-> gpio_hiz_out)
      else $error("gpio driven in reset");
  chk_subs_held:
    assert property (master_reset_out |-> control_reset_out
      && analog_reset_out) else $error("subsystem left reset");
  chk_release_cause:
    assert property ($fell(control_reset_out) |->
      $past(control_reset_release_in)) else $error("release uncaused");
  chk_src_mapping:
    assert property (master_load_out || master_run_out |->
      master_src_out == want_src) else $error("boot source wrong");
  chk_strap_once:
    assert property (master_run_out && $past(master_run_out) |->
      $stable(strap_latched_out)) else $error("strap resampled");
  chk_noload_modes:
    assert property (master_load_out |-> !(master_src_out inside
      {4'h1, 4'h7})) else $error("load in no-load mode");
  chk_cmd_source:
    assert property (cmd_taken_out |-> $past(cmd_valid_in) && control_src_out
      == $past(control_boot_command_mailbox_in[2:0])) else $error("bad src");
  chk_cmd_action:
    assert property (cmd_taken_out |-> control_load_out == (control_src_out
      > 3'h2) && control_run_out != control_load_out) else $error("bad act");
  chk_cmd_ignore:
    assert property (cmd_ignored_out |-> $stable(control_src_out) &&
      !($past(control_boot_command_mailbox_in) inside {[32'h1:32'h6]}))
      else $error("bad ignore");
  cover property (master_load_out ##[1:8] master_run_out);
  cover property ($fell(control_reset_out));
  cover property (cmd_taken_out && control_load_out);
  cover property (cmd_ignored_out);
endmodule : bmrs_checker
bind bmrs_sequencer bmrs_checker u_chk
(
  .mclk_in, .rst_in, .por_n_in, .digital_reset_pin_in,
  .analog_reset_pin_oe_out, .digital_reset_pin_oe_out,
  .irq_ctrl_rst_req_in, .wdog0_rst_req_in, .wdog1_rst_req_in,
  .nmi_wdog_rst_req_in, .control_reset_release_in, .cmd_valid_in,
  .master_reset_out, .control_reset_out, .analog_reset_out, .gpio_hiz_out,
  .master_load_out, .master_run_out, .control_load_out, .control_run_out,
  .cmd_taken_out, .cmd_ignored_out, .control_boot_command_mailbox_in,
  .strap_latched_out, .master_src_out, .control_src_out
);
`default_nettype wire

// ### test/boot_mode_reset_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// boot and reset sequencing tests
// --------------------------------
module boot_mode_reset_sequencer_test;
  logic        clk = 1'b0, rst = 1'b1, por_n = 1'b0, hold = 1'b0;
  logic        c_rel = 1'b0, a_rel = 1'b0, wake = 1'b0, cv = 1'b0;
  logic [3:0]  req = 4'h0, strap = 4'h0;
  logic [31:0] cmd = 32'h0;
  logic        ars_n, drs_n, a_oe_n, d_oe_n, m_done, c_done, ld, taken;
  logic        m_rst, c_rst, a_rst, hiz, m_load, m_run, c_load, c_run, ign;
  logic        c_idle;
  logic [3:0]  s_lat, m_src;
  logic [2:0]  c_src;
  int          mismatches = 0, n_compared = 0;
  initial forever #25 clk = ~clk;
  bmrs_sequencer DUT
  (
    .mclk_in(clk), .rst_in(rst), .por_n_in(por_n),
    .analog_reset_pin_in(ars_n), .analog_reset_pin_out(),
    .analog_reset_pin_oe_out(a_oe_n), .digital_reset_pin_in(drs_n),
    .digital_reset_pin_out(), .digital_reset_pin_oe_out(d_oe_n),
    .irq_ctrl_rst_req_in(req[0]), .wdog0_rst_req_in(req[1]),
    .wdog1_rst_req_in(req[2]), .nmi_wdog_rst_req_in(req[3]),
    .strap_in(strap), .master_load_done_in(m_done),
    .control_reset_release_in(c_rel), .analog_reset_release_in(a_rel),
    .master_to_control_wake_irq_in(wake), .cmd_valid_in(cv),
    .control_boot_command_mailbox_in(cmd), .control_load_done_in(c_done),
    .master_reset_out(m_rst), .control_reset_out(c_rst),
    .analog_reset_out(a_rst), .gpio_hiz_out(hiz),
    .strap_latched_out(s_lat), .master_src_out(m_src),
    .master_load_out(m_load), .master_run_out(m_run),
    .control_idle_out(c_idle), .control_src_out(c_src),
    .control_load_out(c_load), .control_run_out(c_run),
    .cmd_taken_out(taken), .cmd_ignored_out(ign)
  );
  bmrs_board BRD
  (
    .clk_in(clk), .a_oe_n_in(a_oe_n), .d_oe_n_in(d_oe_n), .hold_in(hold),
    .m_load_in(m_load), .c_load_in(c_load), .a_pin_n_out(ars_n),
    .d_pin_n_out(drs_n), .m_done_out(m_done), .c_done_out(c_done)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic wait_run(input logic ctl);
    int i;
    ld = 1'b0;
    for (i = 0; i < 30 && (ctl ? c_run : m_run) !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
      ld = ld | m_load;
    end
    if (i == 30)
    begin
      $display("CHECK FAILED at %0t: run state not reached", $time);
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_run
  task automatic boot(input logic [3:0] s);
    @(posedge clk);
    rst <= 1'b1;
    strap <= s;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    wait_run(1'b0);
  endtask : boot
  task automatic send(input logic [31:0] c);
    @(posedge clk);
    cv <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask : send
  initial
  begin : main
    int s;
    logic [2:0] ecs;
    repeat (5) @(posedge clk);
    #1;
    check({a_oe_n, d_oe_n}, 2'b00);
    check({hiz, c_rst, a_rst}, 3'b111);
    @(posedge clk);
    por_n <= 1'b1;
    rst <= 1'b0;
    for (s = 0; s < 16; s++)
    begin
      boot(s[3:0]);
      check(m_src, (s inside {0, 1, 2, 3, 4, 7, 9, 10}) ? s : 7);
      check(ld, s inside {0, 2, 3, 4, 9, 10});
      check({c_rst, a_rst}, 2'b11);
      @(posedge clk);
      strap <= ~s[3:0];
      repeat (2) @(posedge clk);
      #1;
      check(s_lat, s);
    end
    $display("strap test done");
    for (s = 0; s < 6; s++)
    begin
      @(posedge clk);
      req <= (s < 4) ? 4'h1 << s : 4'h0;
      hold <= (s == 4);
      por_n <= (s != 5);
      @(posedge clk);
      #1;
      check(d_oe_n, s == 4);
      check(a_oe_n, s != 5);
      check({hiz, m_run}, 2'b10);
    end
    @(posedge clk);
    hold <= 1'b0;
    por_n <= 1'b1;
    $display("reset test done");
    boot(4'h7);
    @(posedge clk);
    c_rel <= 1'b1;
    a_rel <= 1'b1;
    @(posedge clk);
    c_rel <= 1'b0;
    a_rel <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({c_rst, a_rst, m_rst, c_idle}, 4'b0001);
    send(32'h2);
    check({taken, ign, c_idle}, 3'b001);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1;
    check(c_idle, 1'b0);
    ecs = 3'h0;
    for (s = 0; s < 8; s++)
    begin
      send(s);
      check({taken, ign}, (s inside {[1:6]}) ? 2'b10 : 2'b01);
      if (s inside {[1:6]})
      begin
        ecs = s[2:0];
        wait_run(1'b1);
      end
      check(c_src, ecs);
      check(c_run, s > 0);
    end
    $display("control test done");
    tally_and_finish();
  end
endmodule : boot_mode_reset_sequencer_test
`default_nettype wire
